/* hdl/pikw_top.sv */
// Functional notes
// - maskable request pin: active-low level or falling edge, chosen by control
// - non-maskable pin is an active-low level request, unmaskable once enabled
// - non-maskable mask bit is set by reset; software clears it
// - maskable request off after reset; needs enable set and cpu mask clear
// - clearing the maskable enable withdraws a pending request at once
// - both external request pins wake the device from stop
// - no glitch filter on the external request pins
// - ports AD, P, L: per-pin interrupt enable and edge polarity
// - one shared interrupt output per port
// - pin interrupts work whether the pin is input or output
// - port request when any flag and its enable are both set
// - enabled pin interrupt wakes from stop or wait
// - valid edge: 4 passive samples then 4 active samples
// - broken sample sequence restarts the filter
// - filters sampled every bus clock in run and wait
// - filters sampled on rc oscillator ticks in stop
// - port L polarity bits 2-0: one rising, zero falling
// - every source gated by local enable; non-maskable pin has none
`timescale 1ns/10ps
`default_nettype none
`include "pikw_map.svh"
module pikw_top (
    // clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // avalon-mm slave
    input  wire logic [11:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // pins
    input  wire logic        EXT_REQUEST_N,
    input  wire logic        NONMASKABLE_REQUEST_PIN_N,
    input  wire logic [15:0] PORT_AD_PINS,
    input  wire logic [7:0]  PORT_P_PINS,
    input  wire logic [2:0]  PORT_L_PINS,
    input  wire logic        RC_OSC_CLK,
    input  wire logic        OC_T_FAULT,
    input  wire logic        OC_P_FAULT,
    // power mode
    input  wire logic        STOP_MODE,
    input  wire logic        WAIT_MODE,
    // cpu side
    output logic             IRQ_REQ,
    output logic             NONMASKABLE_REQUEST_PIN_REQ,
    output logic             PORT_AD_INT,
    output logic             PORT_P_INT,
    output logic             PORT_L_INT,
    output logic             OC_T_INT,
    output logic             OC_P_INT,
    output logic             WAKEUP_REQ
);
    // ************************************************
    // state
    // ************************************************
    pikw_pkg::pikw_state_t r_ff;
    pikw_pkg::pikw_state_t nxt_r;
    logic                   acc;
    logic                   wr_go;
    logic                   samp_en;
    logic                   fall;
    logic                   ext_act;
    logic                   pin_any;
    logic [15:0]            bm;
    pikw_pkg::pikw_vec_t    clr;
    pikw_pkg::pikw_vec_t    edges;
    pikw_pkg::pikw_vec_t    act;
    logic [31:0]            rd;
    logic [4:0]             fs;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    // returns {edge, phase, count}
    function automatic logic [4:0] filt_step(input logic [3:0] st,
                                             input logic       a);
        logic [4:0] res;
        res = {1'b0, st};
        if (!st[3]) begin
            if (!a) begin
                if (st[2:0] != `PIKW_FILT_N) begin
                    res[2:0] = st[2:0] + 3'h1;
                end
            end else if (st[2:0] == `PIKW_FILT_N) begin
                res[3:0] = {1'b1, 3'h1};
            end else begin
                res[3:0] = 4'h0;
            end
        end else begin
            if (a) begin
                if (st[2:0] == `PIKW_FILT_LAST) begin
                    res = {1'b1, 4'h0};
                end else begin
                    res[2:0] = st[2:0] + 3'h1;
                end
            end else begin
                // this passive sample counts as the first of a new run
                res[3:0] = {1'b0, 3'h1};
            end
        end
        filt_step = res;
    endfunction

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        nxt_r = r_ff;
        acc = AVS_READ | AVS_WRITE;
        wr_go = AVS_WRITE & ~r_ff.waitreq;
        bm = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        clr = '0;
        edges = '0;
        act = '0;
        rd = 32'h0;
        fs = 5'h0;

        // synchronisers, no filter on the request pins
        nxt_r.xs = {r_ff.xs[0], NONMASKABLE_REQUEST_PIN_N};
        nxt_r.is = {r_ff.is[1:0], EXT_REQUEST_N};
        nxt_r.rs = {r_ff.rs[1:0], RC_OSC_CLK};
        nxt_r.oc1 = {OC_P_FAULT, OC_T_FAULT};
        nxt_r.oc2 = r_ff.oc1;
        // pin level is read whatever the pin direction
        nxt_r.p1 = {PORT_L_PINS, PORT_P_PINS, PORT_AD_PINS};
        nxt_r.p2 = r_ff.p1;

        // filter sampling: bus clock in run/wait, rc ticks in stop
        samp_en = STOP_MODE ? (r_ff.rs[1] & ~r_ff.rs[2])
                            : 1'b1;
        for (int i = 0; i < `PIKW_NPIN; i++) begin
            act[i] = r_ff.p2[i] ~^ r_ff.pol[i];
            fs = filt_step(r_ff.filt[i], act[i]);
            if (samp_en) begin
                nxt_r.filt[i] = fs[3:0];
                edges[i] = fs[4];
            end
        end

        // ************************************************
        // register writes
        // ************************************************
        if (wr_go) begin
            if (hit(AVS_ADDRESS, `PIKW_OFS_EXTCTL) &&
                AVS_BYTEENABLE[0]) begin
                nxt_r.irq_edge = AVS_WRITEDATA[`PIKW_EXT_EDGE];
                nxt_r.irq_en = AVS_WRITEDATA[`PIKW_EXT_EN];
            end
            if (hit(AVS_ADDRESS, `PIKW_OFS_CCMASK) &&
                AVS_BYTEENABLE[0]) begin
                nxt_r.imask = AVS_WRITEDATA[`PIKW_CC_I];
                // once cleared it cannot be set again until reset
                nxt_r.xmask = r_ff.xmask & AVS_WRITEDATA[`PIKW_CC_X];
            end
            if (hit(AVS_ADDRESS, `PIKW_OFS_AD_EN)) begin
                nxt_r.en[15:0] = (r_ff.en[15:0] & ~bm)
                               | (AVS_WRITEDATA[15:0] & bm);
            end
            if (hit(AVS_ADDRESS, `PIKW_OFS_AD_POL)) begin
                nxt_r.pol[15:0] = (r_ff.pol[15:0] & ~bm)
                                | (AVS_WRITEDATA[15:0] & bm);
            end
            if (hit(AVS_ADDRESS, `PIKW_OFS_AD_FLG)) begin
                clr[15:0] = AVS_WRITEDATA[15:0] & bm;
            end
            if (AVS_BYTEENABLE[0]) begin
                if (hit(AVS_ADDRESS, `PIKW_OFS_P_EN)) begin
                    nxt_r.en[`PIKW_P_LSB +: `PIKW_P_W] =
                        AVS_WRITEDATA[7:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_P_POL)) begin
                    nxt_r.pol[`PIKW_P_LSB +: `PIKW_P_W] =
                        AVS_WRITEDATA[7:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_P_FLG)) begin
                    clr[`PIKW_P_LSB +: `PIKW_P_W] = AVS_WRITEDATA[7:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_L_EN)) begin
                    nxt_r.en[`PIKW_L_LSB +: `PIKW_L_W] =
                        AVS_WRITEDATA[2:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_L_POL)) begin
                    nxt_r.pol[`PIKW_L_LSB +: `PIKW_L_W] =
                        AVS_WRITEDATA[2:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_L_FLG)) begin
                    clr[`PIKW_L_LSB +: `PIKW_L_W] = AVS_WRITEDATA[2:0];
                end
                if (hit(AVS_ADDRESS, `PIKW_OFS_OC_EN)) begin
                    nxt_r.oc_en = AVS_WRITEDATA[1:0];
                end
            end
        end

        // set beats clear so no edge is lost during a clear
        nxt_r.flag = (r_ff.flag & ~clr) | edges;

        // ************************************************
        // maskable and non-maskable external requests
        // ************************************************
        fall = r_ff.is[2] & ~r_ff.is[1];
        nxt_r.irq_pend = ((r_ff.irq_pend & ~(wr_go & AVS_BYTEENABLE[0]
                         & hit(AVS_ADDRESS, `PIKW_OFS_EXTCTL)
                         & AVS_WRITEDATA[`PIKW_EXT_CLRP]))
                         | (fall & r_ff.irq_edge))
                         & nxt_r.irq_en;
        ext_act = r_ff.irq_en & (r_ff.irq_edge ? r_ff.irq_pend
                                               : ~r_ff.is[1]);
        nxt_r.irq_req = ext_act & ~r_ff.imask;
        nxt_r.nonmaskable_request_pin_req = ~r_ff.xs[1] & ~r_ff.xmask;

        // ************************************************
        // port and over-current requests, wakeup
        // ************************************************
        nxt_r.ad_int = |(r_ff.flag[15:0] & r_ff.en[15:0]);
        nxt_r.p_int = |(r_ff.flag[`PIKW_P_LSB +: `PIKW_P_W]
                      & r_ff.en[`PIKW_P_LSB +: `PIKW_P_W]);
        nxt_r.l_int = |(r_ff.flag[`PIKW_L_LSB +: `PIKW_L_W]
                      & r_ff.en[`PIKW_L_LSB +: `PIKW_L_W]);
        nxt_r.oct_int = r_ff.oc2[0] & r_ff.oc_en[0];
        nxt_r.ocp_int = r_ff.oc2[1] & r_ff.oc_en[1];
        pin_any = |(r_ff.flag & r_ff.en);
        nxt_r.wake = ((STOP_MODE | WAIT_MODE) & pin_any)
                   | (STOP_MODE & (ext_act | ~r_ff.xs[1]));

        // ************************************************
        // read mux and handshake
        // ************************************************
        case ({2'h0, AVS_ADDRESS[11:2]})
            `PIKW_OFS_EXTCTL >> 2: begin
                rd[`PIKW_EXT_EDGE] = r_ff.irq_edge;
                rd[`PIKW_EXT_EN] = r_ff.irq_en;
            end
            `PIKW_OFS_CCMASK >> 2: begin
                rd[`PIKW_CC_I] = r_ff.imask;
                rd[`PIKW_CC_X] = r_ff.xmask;
            end
            `PIKW_OFS_AD_EN >> 2:  rd[15:0] = r_ff.en[15:0];
            `PIKW_OFS_AD_POL >> 2: rd[15:0] = r_ff.pol[15:0];
            `PIKW_OFS_AD_FLG >> 2: rd[15:0] = r_ff.flag[15:0];
            `PIKW_OFS_P_EN >> 2:   rd[7:0] = r_ff.en[23:16];
            `PIKW_OFS_P_POL >> 2:  rd[7:0] = r_ff.pol[23:16];
            `PIKW_OFS_P_FLG >> 2:  rd[7:0] = r_ff.flag[23:16];
            `PIKW_OFS_L_EN >> 2:   rd[2:0] = r_ff.en[26:24];
            `PIKW_OFS_L_FLG >> 2:  rd[2:0] = r_ff.flag[26:24];
            `PIKW_OFS_L_POL >> 2:  rd[2:0] = r_ff.pol[26:24];
            `PIKW_OFS_OC_EN >> 2:  rd[1:0] = r_ff.oc_en;
            `PIKW_OFS_STAT >> 2:   rd[26:0] = r_ff.p2;
            default:               rd = 32'h0;
        endcase
        // one wait state: data is latched on the same edge that drops waitrequest
        nxt_r.waitreq = ~(acc & r_ff.waitreq);
        if (acc & r_ff.waitreq) begin
            nxt_r.rdata = AVS_READ ? rd : 32'h0;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            r_ff <= '0;
            r_ff.xs <= 2'h3;
            r_ff.is <= 3'h7;
            r_ff.xmask <= 1'b1;
            r_ff.imask <= 1'b1;
            r_ff.irq_en <= 1'b0;
            r_ff.pol[26:24] <= `PIKW_RST_L_POL;
            r_ff.waitreq <= 1'b1;
        end else if (CE) begin
            r_ff <= nxt_r;
        end
    end

    assign AVS_READDATA    = r_ff.rdata;
    assign AVS_WAITREQUEST = r_ff.waitreq;
    assign IRQ_REQ         = r_ff.irq_req;
    assign NONMASKABLE_REQUEST_PIN_REQ        = r_ff.nonmaskable_request_pin_req;
    assign PORT_AD_INT     = r_ff.ad_int;
    assign PORT_P_INT      = r_ff.p_int;
    assign PORT_L_INT      = r_ff.l_int;
    assign OC_T_INT        = r_ff.oct_int;
    assign OC_P_INT        = r_ff.ocp_int;
    assign WAKEUP_REQ      = r_ff.wake;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    AST_IRQ_LEVEL: assert property (
        CE && !r_ff.irq_edge && r_ff.irq_en && !r_ff.imask
        && !r_ff.is[1] |=> IRQ_REQ)
        else $error("level request not raised");
    AST_NONMASKABLE_REQUEST_PIN_LEVEL: assert property (
        CE && !r_ff.xmask && !r_ff.xs[1] |=> NONMASKABLE_REQUEST_PIN_REQ)
        else $error("non-maskable request not raised");
    AST_XMASK_RST: assert property (
        $rose(RST_N) |-> r_ff.xmask && !NONMASKABLE_REQUEST_PIN_REQ)
        else $error("non-maskable mask not set by reset");
    AST_IRQ_OFF: assert property (
        CE && !r_ff.irq_en |=> !IRQ_REQ)
        else $error("disabled request reached cpu");
    AST_PEND_DROP: assert property (
        CE && r_ff.irq_pend && !nxt_r.irq_en |=> !r_ff.irq_pend)
        else $error("pending request kept after disable");
    AST_PORT_REQ: assert property (
        CE && (r_ff.flag[0] && r_ff.en[0]) |=> PORT_AD_INT)
        else $error("port request missing");
    AST_FILT_EDGE: assert property (
        CE && samp_en && r_ff.filt[0] == {1'b1, `PIKW_FILT_LAST}
        && act[0] |=> r_ff.flag[0] && r_ff.filt[0] == 4'h0)
        else $error("fourth active sample gave no edge");
    AST_FILT_RESTART: assert property (
        CE && samp_en && r_ff.filt[0][3] && !act[0]
        |=> r_ff.filt[0] == {1'b0, 3'h1})
        else $error("broken sequence not restarted");
    AST_STOP_HOLD: assert property (
        CE && STOP_MODE && !(r_ff.rs[1] && !r_ff.rs[2])
        |=> $stable(r_ff.filt))
        else $error("filter moved without rc tick in stop");
    AST_WAKE: assert property (
        CE && (STOP_MODE || WAIT_MODE) && pin_any |=> WAKEUP_REQ)
        else $error("pin interrupt did not wake");
    AST_FLAG_HOLD: assert property (
        CE && r_ff.flag[0] && !clr[0] |=> r_ff.flag[0])
        else $error("flag lost without clear");
    // masks, wake and flag corner cases
    AST_IRQ_MASKED: assert property (
        CE && r_ff.imask |=> !IRQ_REQ)
        else $error("masked request reached cpu");
    AST_NONMASKABLE_REQUEST_PIN_MASKED: assert property (
        CE && r_ff.xmask |=> !NONMASKABLE_REQUEST_PIN_REQ)
        else $error("non-maskable request passed its mask");
    AST_EDGE_PEND: assert property (
        CE && fall && r_ff.irq_edge && nxt_r.irq_en |=> r_ff.irq_pend)
        else $error("falling edge not held pending");
    AST_EXT_WAKE: assert property (
        CE && STOP_MODE && !r_ff.xs[1] |=> WAKEUP_REQ)
        else $error("non-maskable pin did not wake");
    AST_RUN_NO_WAKE: assert property (
        CE && !STOP_MODE && !WAIT_MODE |=> !WAKEUP_REQ)
        else $error("wake raised in run mode");
    AST_PASSIVE_NO_EDGE: assert property (
        CE && !r_ff.filt[0][3] && !r_ff.flag[0] |=> !r_ff.flag[0])
        else $error("edge seen without an active run");
    AST_SET_WINS: assert property (
        CE && edges[0] |=> r_ff.flag[0])
        else $error("edge lost to a clear");
    AST_L_REQ: assert property (
        CE && |(r_ff.flag[26:24] & r_ff.en[26:24]) |=> PORT_L_INT)
        else $error("port l request missing");
    AST_OC_GATE: assert property (
        CE && !r_ff.oc_en[0] |=> !OC_T_INT)
        else $error("over-current request passed a clear enable");

    COV_EDGE: cover property (CE && edges[0]);
    COV_STOP_WAKE: cover property (STOP_MODE && WAKEUP_REQ);
    COV_IRQ_EDGE: cover property (r_ff.irq_edge && IRQ_REQ);
    COV_SET_CLR: cover property (CE && edges[0] && clr[0]);
    COV_L_REQ: cover property (CE && PORT_L_INT);
endmodule
`default_nettype wire

/* pkg/pikw_map.svh */
`ifndef PIKW_MAP_SVH
`define PIKW_MAP_SVH
// ************************************************
// pin groups
// ************************************************
`define PIKW_AD_W       16
`define PIKW_P_W        8
`define PIKW_L_W        3
`define PIKW_NPIN       27
`define PIKW_P_LSB      16
`define PIKW_L_LSB      24
// ************************************************
// filter
// ************************************************
`define PIKW_FILT_N     3'h4
`define PIKW_FILT_LAST  3'h3
// ************************************************
// register byte offsets
// ************************************************
`define PIKW_OFS_EXTCTL 12'h300
`define PIKW_OFS_CCMASK 12'h304
`define PIKW_OFS_AD_EN  12'h308
`define PIKW_OFS_AD_POL 12'h30c
`define PIKW_OFS_AD_FLG 12'h310
`define PIKW_OFS_P_EN   12'h314
`define PIKW_OFS_P_POL  12'h318
`define PIKW_OFS_P_FLG  12'h31c
`define PIKW_OFS_L_EN   12'h320
`define PIKW_OFS_L_FLG  12'h324
`define PIKW_OFS_OC_EN  12'h328
`define PIKW_OFS_STAT   12'h32c
`define PIKW_OFS_L_POL  12'h334
// ************************************************
// fields and reset values
// ************************************************
`define PIKW_EXT_EDGE   0
`define PIKW_EXT_CLRP   1
`define PIKW_EXT_EN     6
`define PIKW_CC_I       0
`define PIKW_CC_X       1
`define PIKW_RST_L_POL  3'h0
`endif

/* pkg/pikw_pkg.sv */
`default_nettype none
package pikw_pkg;
`include "pikw_map.svh"
    typedef logic [`PIKW_NPIN-1:0] pikw_vec_t;
    typedef struct packed {
        logic [1:0]                    xs;
        logic [2:0]                    is;
        logic [2:0]                    rs;
        logic [1:0]                    oc1;
        logic [1:0]                    oc2;
        pikw_vec_t                     p1;
        pikw_vec_t                     p2;
        logic [`PIKW_NPIN-1:0][3:0]    filt;
        pikw_vec_t                     en;
        pikw_vec_t                     pol;
        pikw_vec_t                     flag;
        logic                          irq_edge;
        logic                          irq_en;
        logic                          irq_pend;
        logic                          imask;
        logic                          xmask;
        logic [1:0]                    oc_en;
        logic                          waitreq;
        logic [31:0]                   rdata;
        logic                          irq_req;
        logic                          nonmaskable_request_pin_req;
        logic                          ad_int;
        logic                          p_int;
        logic                          l_int;
        logic                          oct_int;
        logic                          ocp_int;
        logic                          wake;
    } pikw_state_t;
endpackage
`default_nettype wire

/* testbench/pikw_pins.sv */
`timescale 1ns/10ps
`default_nettype none
module pikw_pins (
    // timing reference
    input  wire logic        mclk,
    // request pins, idle high
    output logic             ext_n,
    output logic             nonmaskable_request_pin_n,
    // port pins
    output logic [15:0]      ad,
    output logic [7:0]       p,
    output logic [2:0]       l,
    // rc oscillator, runs free in every mode
    output logic             rc_clk
);
    initial begin
        ext_n = 1'b1;
        nonmaskable_request_pin_n = 1'b1;
        ad = 16'h0;
        p = 8'h0;
        l = 3'h0;
        rc_clk = 1'b0;
    end
    // 700 ns period is exactly seven bus clock periods, so rc edges land on bus clock edges
    always #350 rc_clk = ~rc_clk;
    task put_req(input logic i_n, input logic x_n);
        @(posedge mclk);
        ext_n <= i_n;
        nonmaskable_request_pin_n <= x_n;
    endtask
    task put_pins(input logic [26:0] v);
        @(posedge mclk);
        ad <= v[15:0];
        p <= v[23:16];
        l <= v[26:24];
    endtask
endmodule
`default_nettype wire

/* testbench/tb_pikw_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pikw_top;
    // ****
    // signals
    // ****
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] adr = 12'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic        stop = 1'b0;
    logic        wmode = 1'b0;
    logic        ce = 1'b1;
    logic [1:0]  oc = 2'h0;
    logic [26:0] cur = 27'h0;
    logic [31:0] q, msk, pol, en;
    wire logic [31:0] rdat;
    wire logic [15:0] ad;
    wire logic [7:0]  pp;
    wire logic [2:0]  pl;
    wire logic        wreq, irq, nonmaskable_request_pin, ad_i, p_i, l_i, oct, ocp, wake;
    wire logic        ext_n, nonmaskable_request_pin_n, rc;
    int          failures = 0;
    int          check_count = 0;
    int          seed, i, k, b;
    logic [11:0] oe[3] = '{12'h308, 12'h314, 12'h320};
    logic [11:0] op[3] = '{12'h30c, 12'h318, 12'h334};
    logic [11:0] of[3] = '{12'h310, 12'h31c, 12'h324};
    int          lsb[3] = '{0, 16, 24};
    int          wid[3] = '{16, 8, 3};
    always #50 mclk = ~mclk;
    pikw_pins pk (.mclk(mclk), .ext_n(ext_n), .nonmaskable_request_pin_n(nonmaskable_request_pin_n), .ad(ad),
                  .p(pp), .l(pl), .rc_clk(rc));
    pikw_top uut (
        .MCLK(mclk), .RST_N(rst_n), .CE(ce),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .EXT_REQUEST_N(ext_n), .NONMASKABLE_REQUEST_PIN_N(nonmaskable_request_pin_n),
        .PORT_AD_PINS(ad), .PORT_P_PINS(pp), .PORT_L_PINS(pl),
        .RC_OSC_CLK(rc), .OC_T_FAULT(oc[0]), .OC_P_FAULT(oc[1]),
        .STOP_MODE(stop), .WAIT_MODE(wmode),
        .IRQ_REQ(irq), .NONMASKABLE_REQUEST_PIN_REQ(nonmaskable_request_pin), .PORT_AD_INT(ad_i),
        .PORT_P_INT(p_i), .PORT_L_INT(l_i), .OC_T_INT(oct),
        .OC_P_INT(ocp), .WAKEUP_REQ(wake));
    // ****
    // tasks
    // ****
    task tally_and_finish;
        $display("comparisons %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        // hold until waitrequest is seen low; the watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] flag_of(input int n);
        return 32'h1 << n;
    endfunction
    // every pin of one port at its passive level, others untouched
    function automatic logic [26:0] park(input logic [26:0] c,
                                         input logic [31:0] m,
                                         input logic [31:0] p,
                                         input int          s);
        return 27'((c & ~(m << s)) | ((~p & m) << s));
    endfunction
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task pins(input logic [26:0] v);
        cur = v;
        pk.put_pins(v);
    endtask
    task burst(input logic [26:0] x, input int n);
        logic [26:0] s;
        s = cur;
        pins(cur ^ x);
        cyc(n - 1);
        pins(s);
    endtask
    initial begin
        // tests need about a thousand cycles; this allows twenty thousand
        #2000000;
        failures++;
        tally_and_finish;
    end
    initial begin
        seed = 32'h923ca9b5;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(12'h304, 32'h3);
        rchk(12'h300, 32'h0);
        rchk(12'h334, 32'h0);
        rchk(12'h3f0, 32'h0);
        pk.put_req(1'b1, 1'b0);
        cyc(6);
        chk1(nonmaskable_request_pin, 1'b0);
        bus(1'b1, 12'h304, 32'h1);
        cyc(4);
        chk1(nonmaskable_request_pin, 1'b1);
        bus(1'b1, 12'h304, 32'h3);
        cyc(4);
        chk1(nonmaskable_request_pin, 1'b1);
        stop <= 1'b1;
        cyc(4);
        chk1(wake, 1'b1);
        stop <= 1'b0;
        pk.put_req(1'b0, 1'b1);
        bus(1'b1, 12'h304, 32'h0);
        cyc(6);
        chk1(irq, 1'b0);
        bus(1'b1, 12'h300, 32'h40);
        cyc(4);
        chk1(irq, 1'b1);
        stop <= 1'b1;
        cyc(3);
        chk1(wake, 1'b1);
        stop <= 1'b0;
        bus(1'b1, 12'h300, 32'h0);
        cyc(2);
        chk1(irq, 1'b0);
        pk.put_req(1'b1, 1'b1);
        bus(1'b1, 12'h300, 32'h41);
        // single-cycle low: only seen because no filter sits here
        pk.put_req(1'b0, 1'b1);
        pk.put_req(1'b1, 1'b1);
        cyc(5);
        chk1(irq, 1'b1);
        bus(1'b1, 12'h300, 32'h43);
        cyc(3);
        chk1(irq, 1'b0);
        pk.put_req(1'b0, 1'b1);
        pk.put_req(1'b1, 1'b1);
        cyc(5);
        bus(1'b1, 12'h300, 32'h1);
        cyc(2);
        chk1(irq, 1'b0);
        // re-enable: the edge pending before the disable was dropped, so no request shows here
        bus(1'b1, 12'h300, 32'h41);
        cyc(3);
        chk1(irq, 1'b0);
        bus(1'b1, 12'h30c, 32'h8);
        bus(1'b1, 12'h308, 32'h8);
        cyc(10);
        burst(27'h8, 3);
        cyc(12);
        rchk(12'h310, 32'h0);
        burst(27'h8, 4);
        cyc(12);
        rchk(12'h310, 32'h8);
        chk1(ad_i, 1'b1);
        bus(1'b1, 12'h308, 32'h0);
        cyc(2);
        chk1(ad_i, 1'b0);
        rchk(12'h310, 32'h8);
        bus(1'b1, 12'h310, 32'h8);
        rchk(12'h310, 32'h0);
        for (i = 0; i < 6; i++) begin
            k = i % 3;
            msk = (32'h1 << wid[k]) - 1;
            pol = $random(seed) & msk;
            en = $random(seed) & msk;
            b = {$random(seed)} % wid[k];
            bus(1'b1, op[k], pol);
            rchk(op[k], pol);
            bus(1'b1, oe[k], en);
            pins(park(cur, msk, pol, lsb[k]));
            cyc(12);
            bus(1'b1, of[k], msk);
            pins(cur ^ 27'(flag_of(lsb[k] + b)));
            cyc(12);
            rchk(of[k], flag_of(b));
            chk1(k == 0 ? ad_i : k == 1 ? p_i : l_i, en[b]);
            bus(1'b1, of[k], msk);
            bus(1'b1, oe[k], 32'h0);
        end
        bus(1'b1, 12'h30c, 32'h1);
        bus(1'b1, 12'h308, 32'h1);
        pins(cur & ~27'h1);
        cyc(12);
        bus(1'b1, 12'h310, 32'hffff);
        stop <= 1'b1;
        cyc(60);
        // 400 ns pulse spans at most one rc tick
        burst(27'h1, 4);
        cyc(60);
        rchk(12'h310, 32'h0);
        chk1(wake, 1'b0);
        pins(cur | 27'h1);
        cyc(60);
        rchk(12'h310, 32'h1);
        chk1(wake, 1'b1);
        stop <= 1'b0;
        wmode <= 1'b1;
        cyc(3);
        chk1(wake, 1'b1);
        wmode <= 1'b0;
        cyc(3);
        chk1(wake, 1'b0);
        oc <= 2'h3;
        cyc(5);
        chk({30'h0, ocp, oct}, 32'h0);
        bus(1'b1, 12'h328, 32'h1);
        cyc(4);
        chk({30'h0, ocp, oct}, 32'h1);
        bus(1'b1, 12'h328, 32'h2);
        cyc(4);
        chk({30'h0, ocp, oct}, 32'h2);
        rchk(12'h32c, {5'h0, cur});
        // frozen enable: a fault change must not reach the outputs
        ce <= 1'b0;
        oc <= 2'h0;
        cyc(5);
        chk({30'h0, ocp, oct}, 32'h2);
        ce <= 1'b1;
        cyc(5);
        chk({30'h0, ocp, oct}, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
